// ==== inc/arp_defines.vh ====
// Purpose: shared constants for the cipher round and carry-less multiply datapath
// Assumes: included by its bare name from rtl/
// Notes:   definitions only
`ifndef ARP_DEFINES_VH
`define ARP_DEFINES_VH

// ----------------------------------------------------------------
// operation codes on op_i
// ----------------------------------------------------------------
`define ARP_OP_W          4
`define ARP_OP_ENC        4'h0
`define ARP_OP_ENC_LAST   4'h1
`define ARP_OP_DEC        4'h2
`define ARP_OP_DEC_LAST   4'h3
`define ARP_OP_INV_MIX    4'h4
`define ARP_OP_KEY_ASSIST 4'h5
`define ARP_OP_CLMUL      4'h6
`define ARP_OP_ROW_ROT    4'h7
`define ARP_OP_INV_ROW    4'h8
`define ARP_OP_SUB        4'h9
`define ARP_OP_INV_SUB    4'ha
`define ARP_OP_MIX        4'hb
`define ARP_OP_WORD_SUB   4'hc
`define ARP_OP_WORD_ROT   4'hd

// ----------------------------------------------------------------
// field and table constants
// ----------------------------------------------------------------
`define ARP_POLY          9'h11b
`define ARP_POLY_LOW      8'h1b
`define ARP_AFFINE_FWD    8'h63
`define ARP_AFFINE_INV    8'h05

// ----------------------------------------------------------------
// key lengths and round counts
// ----------------------------------------------------------------
`define ARP_KEY_128       2'h0
`define ARP_KEY_192       2'h1
`define ARP_KEY_256       2'h2
`define ARP_ROUNDS_128    4'ha
`define ARP_ROUNDS_192    4'hc
`define ARP_ROUNDS_256    4'he

// ----------------------------------------------------------------
// timing and carry-less multiply immediate select bits
// ----------------------------------------------------------------
`define ARP_LATENCY       1
`define ARP_CLMUL_SEL_A   0
`define ARP_CLMUL_SEL_B   4

`endif

// ==== rtl/arp_round_core.v ====
// Purpose: cipher round primitives and 64x64 carry-less multiply on 128-bit operands
// Assumes: operands from a pipeline on clk_i; one registered stage from request to result
// Notes:   substitution tables are computed from the field inverse, not stored
`timescale 1ns/1ps
`include "arp_defines.vh"

// Overview of operation
// - state byte 0 is bits 7:0
// - byte k sits at row k%4, column k/4
// - column mix uses 02, 03, 01, 01
// - products reduce by x^8+x^4+x^3+x+1
// - field addition is bitwise exclusive-or
// - bit k is coefficient of x^k
// - product: carry-less multiply, then reduce
// - word rotate gives bytes 0,3,2,1
// - row rotate: row r left by r
// - forward substitution table, 00 gives 63
// - word substitute keeps byte positions
// - inverse mix uses 0e,0b,0d,09 rotated
// - inverse row rotate: row r right r
// - inverse substitution table, 00 gives 52
// - 64x64 carry-less product, 128 bits
// - key lengths 128/192/256 give 10/12/14 rounds
module arp_round_core (
	// clock and reset
	input  wire                   clk_i,
	input  wire                   rst_n_i,
	// request from the pipeline
	input  wire                   valid_i,
	input  wire [`ARP_OP_W-1:0]   op_i,
	input  wire [127:0]           state_i,
	input  wire [127:0]           key_i,
	input  wire [7:0]             imm_i,
	input  wire [1:0]             key_len_i,
	// result to the pipeline
	output wire                   valid_o,
	output wire [127:0]           result_o,
	output wire [3:0]             rounds_o,
	output wire                   illegal_o
);

	// ----------------------------------------------------------------
	// field arithmetic
	// ----------------------------------------------------------------

	// carry-less product then remainder by the field polynomial
	function [7:0] arp_field_multiply;
		input [7:0] a;
		input [7:0] b;
		reg   [14:0] p;
		integer i;
		begin
			p = 15'h0000;
			for (i = 0; i < 8; i = i + 1) begin
				if (b[i])
					p = p ^ ({7'h00, a} << i);
			end
			for (i = 14; i >= 8; i = i - 1) begin
				if (p[i])
					p = p ^ ({6'h00, `ARP_POLY} << (i - 8));
			end
			arp_field_multiply = p[7:0];
		end
	endfunction

	// inverse as a^254 by square and multiply; zero maps to zero
	function [7:0] arp_field_inverse;
		input [7:0] a;
		reg   [7:0] sq;
		reg   [7:0] r;
		integer i;
		begin
			sq = a;
			r  = 8'h01;
			for (i = 1; i < 8; i = i + 1) begin
				sq = arp_field_multiply(sq, sq);
				r  = arp_field_multiply(r, sq);
			end
			arp_field_inverse = r;
		end
	endfunction

	function [7:0] arp_rotl8;
		input [7:0] x;
		input [2:0] n;
		begin
			arp_rotl8 = (x << n) | (x >> (4'h8 - {1'b0, n}));
		end
	endfunction

	// forward table entry: inverse then affine map
	function [7:0] arp_sub_byte;
		input [7:0] x;
		reg   [7:0] v;
		begin
			v = arp_field_inverse(x);
			arp_sub_byte = v ^ arp_rotl8(v, 3'h1) ^ arp_rotl8(v, 3'h2) ^ arp_rotl8(v, 3'h3)
				^ arp_rotl8(v, 3'h4) ^ `ARP_AFFINE_FWD;
		end
	endfunction

	// inverse table entry: inverse affine map then field inverse
	function [7:0] arp_inv_sub_byte;
		input [7:0] x;
		reg   [7:0] v;
		begin
			v = arp_rotl8(x, 3'h1) ^ arp_rotl8(x, 3'h3) ^ arp_rotl8(x, 3'h6) ^ `ARP_AFFINE_INV;
			arp_inv_sub_byte = arp_field_inverse(v);
		end
	endfunction

	// word substitute, byte positions kept
	function [31:0] arp_word_substitute;
		input [31:0] w;
		integer i;
		begin
			arp_word_substitute = 32'h0000_0000;
			for (i = 0; i < 4; i = i + 1)
				arp_word_substitute[8*i +: 8] = arp_sub_byte(w[8*i +: 8]);
		end
	endfunction

	// word rotate: high to low becomes bytes 0,3,2,1
	function [31:0] arp_word_rotate;
		input [31:0] w;
		begin
			arp_word_rotate = {w[7:0], w[31:8]};
		end
	endfunction

	// forward mix of one column, row 0 in the low byte
	function [31:0] arp_column_mix;
		input [31:0] c;
		reg   [7:0] s0, s1, s2, s3;
		begin
			s0 = c[7:0];
			s1 = c[15:8];
			s2 = c[23:16];
			s3 = c[31:24];
			arp_column_mix[7:0]   = arp_field_multiply(8'h02, s0) ^ arp_field_multiply(8'h03, s1) ^ s2 ^ s3;
			arp_column_mix[15:8]  = s0 ^ arp_field_multiply(8'h02, s1) ^ arp_field_multiply(8'h03, s2) ^ s3;
			arp_column_mix[23:16] = s0 ^ s1 ^ arp_field_multiply(8'h02, s2) ^ arp_field_multiply(8'h03, s3);
			arp_column_mix[31:24] = arp_field_multiply(8'h03, s0) ^ s1 ^ s2 ^ arp_field_multiply(8'h02, s3);
		end
	endfunction

	// inverse mix of one column, coefficient row rotated right per output row
	function [31:0] arp_inverse_column_mix;
		input [31:0] c;
		reg   [31:0] k;
		integer r;
		integer i;
		begin
			arp_inverse_column_mix = 32'h0000_0000;
			k = {8'h09, 8'h0d, 8'h0b, 8'h0e};
			for (r = 0; r < 4; r = r + 1) begin
				for (i = 0; i < 4; i = i + 1)
					arp_inverse_column_mix[8*r +: 8] = arp_inverse_column_mix[8*r +: 8]
						^ arp_field_multiply(k[8*i +: 8], c[8*i +: 8]);
				k = {k[23:0], k[31:24]};
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// per-byte row rotation and substitution
	// ----------------------------------------------------------------

	// raw substitute ops feed the tables straight from the operand so one set of tables serves round and raw substitute ops; word ops have their own
	wire         raw_sub_sel;
	wire [127:0] rot_state;
	wire [127:0] inv_rot_state;
	wire [127:0] sub_state;
	wire [127:0] inv_sub_state;
	wire [127:0] mix_state;
	wire [127:0] inv_mix_state;
	wire [127:0] inv_mix_raw;

	assign raw_sub_sel = (op_i == `ARP_OP_SUB) || (op_i == `ARP_OP_INV_SUB);

	genvar k;
	generate
		for (k = 0; k < 16; k = k + 1) begin : g_byte
			// byte k is row k%4, column k/4
			localparam integer ROW = k % 4;
			localparam integer COL = k / 4;
			localparam integer SRC_FWD = 4 * ((COL + ROW) % 4) + ROW;
			localparam integer SRC_INV = 4 * ((COL + 4 - ROW) % 4) + ROW;
			assign rot_state[8*k +: 8]     = state_i[8*SRC_FWD +: 8];
			assign inv_rot_state[8*k +: 8] = state_i[8*SRC_INV +: 8];
			assign sub_state[8*k +: 8]     = arp_sub_byte(raw_sub_sel ? state_i[8*k +: 8]
				: rot_state[8*k +: 8]);
			assign inv_sub_state[8*k +: 8] = arp_inv_sub_byte(raw_sub_sel ? state_i[8*k +: 8]
				: inv_rot_state[8*k +: 8]);
		end
		for (k = 0; k < 4; k = k + 1) begin : g_col
			assign mix_state[32*k +: 32]     = arp_column_mix(sub_state[32*k +: 32]);
			assign inv_mix_state[32*k +: 32] = arp_inverse_column_mix(inv_sub_state[32*k +: 32]);
			assign inv_mix_raw[32*k +: 32]   = arp_inverse_column_mix(state_i[32*k +: 32]);
		end
	endgenerate

	// ----------------------------------------------------------------
	// carry-less multiply
	// ----------------------------------------------------------------

	// immediate bits pick which quadword of each operand enters the product
	reg  [63:0]  clmul_a;
	reg  [63:0]  clmul_b;
	reg  [127:0] clmul_prod;
	integer      n;

	always @* begin
		clmul_a    = imm_i[`ARP_CLMUL_SEL_A] ? state_i[127:64] : state_i[63:0];
		clmul_b    = imm_i[`ARP_CLMUL_SEL_B] ? key_i[127:64] : key_i[63:0];
		clmul_prod = 128'h0;
		for (n = 0; n < 64; n = n + 1) begin
			if (clmul_b[n])
				clmul_prod = clmul_prod ^ ({64'h0, clmul_a} << n);
		end
	end

	// ----------------------------------------------------------------
	// key expansion assist words
	// ----------------------------------------------------------------

	wire [31:0] sub_w1;
	wire [31:0] sub_w3;
	wire [31:0] rcon_w;

	assign sub_w1 = arp_word_substitute(state_i[63:32]);
	assign sub_w3 = arp_word_substitute(state_i[127:96]);
	assign rcon_w = {24'h00_0000, imm_i};

	// ----------------------------------------------------------------
	// result select
	// ----------------------------------------------------------------

	reg [127:0] result_next;
	reg         illegal_next;
	reg [3:0]   rounds_next;

	always @* begin
		illegal_next = 1'b0;
		case (op_i)
			`ARP_OP_ENC:        result_next = mix_state ^ key_i;
			`ARP_OP_ENC_LAST:   result_next = sub_state ^ key_i;
			`ARP_OP_DEC:        result_next = inv_mix_state ^ key_i;
			`ARP_OP_DEC_LAST:   result_next = inv_sub_state ^ key_i;
			`ARP_OP_INV_MIX:    result_next = inv_mix_raw;
			`ARP_OP_KEY_ASSIST: result_next = {arp_word_rotate(sub_w3) ^ rcon_w, sub_w3,
				arp_word_rotate(sub_w1) ^ rcon_w, sub_w1};
			`ARP_OP_CLMUL:      result_next = clmul_prod;
			`ARP_OP_ROW_ROT:    result_next = rot_state;
			`ARP_OP_INV_ROW:    result_next = inv_rot_state;
			`ARP_OP_SUB:        result_next = sub_state;
			`ARP_OP_INV_SUB:    result_next = inv_sub_state;
			`ARP_OP_MIX: begin
				result_next = {arp_column_mix(state_i[127:96]), arp_column_mix(state_i[95:64]),
					arp_column_mix(state_i[63:32]), arp_column_mix(state_i[31:0])};
			end
			`ARP_OP_WORD_SUB:   result_next = {96'h0, arp_word_substitute(state_i[31:0])};
			`ARP_OP_WORD_ROT:   result_next = {96'h0, arp_word_rotate(state_i[31:0])};
			default: begin
				// unknown op answers zero so a stray code never leaks operand data
				result_next  = 128'h0;
				illegal_next = 1'b1;
			end
		endcase
	end

	// round count for the requested key length; reserved length reads zero
	always @* begin
		case (key_len_i)
			`ARP_KEY_128: rounds_next = `ARP_ROUNDS_128;
			`ARP_KEY_192: rounds_next = `ARP_ROUNDS_192;
			`ARP_KEY_256: rounds_next = `ARP_ROUNDS_256;
			default:      rounds_next = 4'h0;
		endcase
	end

	// ----------------------------------------------------------------
	// output stage
	// ----------------------------------------------------------------

	reg         valid_reg;
	reg [127:0] result_reg;
	reg [3:0]   rounds_reg;
	reg         illegal_reg;

	// one registered stage; data only loads on a request so idle results hold still
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			valid_reg   <= 1'b0;
			result_reg  <= 128'h0;
			rounds_reg  <= 4'h0;
			illegal_reg <= 1'b0;
		end else begin
			valid_reg <= valid_i;
			if (valid_i) begin
				result_reg  <= result_next;
				rounds_reg  <= rounds_next;
				illegal_reg <= illegal_next;
			end
		end
	end

	assign valid_o   = valid_reg;
	assign result_o  = result_reg;
	assign rounds_o  = rounds_reg;
	assign illegal_o = illegal_reg;

endmodule // arp_round_core

// ==== test/arp_round_core_chk.sv ====
// Purpose: port checks for the round core
// Assumes: one clock, reset active low
// Notes:   bound at the foot of this file
`timescale 1ns/1ps
module arp_round_core_chk (
	// clock, reset and request
	input wire logic         clk_i,
	input wire logic         rst_n_i,
	input wire logic         valid_i,
	input wire logic [3:0]   op_i,
	input wire logic [127:0] state_i,
	input wire logic [127:0] key_i,
	input wire logic [7:0]   imm_i,
	input wire logic [1:0]   key_len_i,
	// result
	input wire logic         valid_o,
	input wire logic [127:0] result_o,
	input wire logic [3:0]   rounds_o,
	input wire logic         illegal_o
);
	// ------
	// checks
	// ------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// rounds per key length, reserved length gives 0
	function automatic logic [3:0] rnd(input logic [1:0] k);
		return (k == 2'h3) ? 4'h0 : 4'ha + {1'b0, k, 1'b0};
	endfunction
	a_lat_one: assert property (valid_i |=> valid_o)
		else $error("no result one cycle after request");
	a_no_spur: assert property (!valid_i |=> !valid_o)
		else $error("result without request");
	a_res_hold: assert property (!valid_i |=> $stable(result_o) && $stable(rounds_o))
		else $error("result moved without request");
	a_round_map: assert property (valid_i |=> rounds_o == rnd($past(key_len_i)))
		else $error("wrong round count");
	a_bad_op: assert property (valid_i && op_i[3:1] == 3'h7 |=> illegal_o && result_o == 128'h0)
		else $error("undefined op not flagged");
	a_good_op: assert property (valid_i && op_i[3:1] != 3'h7 |=> !illegal_o)
		else $error("defined op flagged");
	a_word_rot: assert property (valid_i && op_i == 4'hd |=>
		result_o == {96'h0, $past(state_i[7:0]), $past(state_i[31:8]), 8'h0} >> 8)
		else $error("word rotate wrong");
	a_row_keep: assert property (valid_i && op_i == 4'h7 |=>
		result_o[15:0] == {$past(state_i[47:40]), $past(state_i[7:0])})
		else $error("row rotate wrong");
	a_clmul_ends: assert property (valid_i && op_i == 4'h6 |=> !result_o[127] &&
		result_o[0] == $past(state_i[{imm_i[0], 6'h0}] & key_i[{imm_i[4], 6'h0}]))
		else $error("carry-less product ends wrong");
	// main scenarios
	c_clmul: cover property (valid_i && op_i == 4'h6);
	c_back: cover property (valid_i [*3]);
	c_bad: cover property (valid_i && op_i == 4'hf);
endmodule // arp_round_core_chk

bind arp_round_core arp_round_core_chk chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .valid_i(valid_i),
	.op_i(op_i), .state_i(state_i), .key_i(key_i), .imm_i(imm_i), .key_len_i(key_len_i),
	.valid_o(valid_o), .result_o(result_o), .rounds_o(rounds_o), .illegal_o(illegal_o));

// ==== test/arp_pipe_src.sv ====
// Purpose: operand source standing in for the pipeline
// Assumes: drives 1 ns after the rising edge
// Notes:   idle scrambles state and key operands; op, imm and length are held
`timescale 1ns/1ps
module arp_pipe_src (
	// clock
	input  wire logic   clk_i,
	// request
	output logic         valid_o,
	output logic [3:0]   op_o,
	output logic [127:0] st_o,
	output logic [127:0] key_o,
	output logic [7:0]   imm_o,
	output logic [1:0]   len_o
);
	// quiet at time zero
	initial begin
		valid_o = 1'b0;
		op_o = 4'h0;
		st_o = 128'h0;
		key_o = 128'h0;
		imm_o = 8'h0;
		len_o = 2'h0;
	end
	// one request per call, calls back to back keep the strobe up
	task automatic send(input logic [3:0] op, input logic [127:0] s, k, input logic [7:0] im, input logic [1:0] kl);
		@(posedge clk_i);
		#1;
		valid_o = 1'b1;
		op_o = op;
		st_o = s;
		key_o = k;
		imm_o = im;
		len_o = kl;
	endtask
	// drop strobe; invert operands so stale data cannot pass
	task automatic idle();
		@(posedge clk_i);
		#1;
		valid_o = 1'b0;
		st_o = ~st_o;
		key_o = ~key_o;
	endtask
endmodule // arp_pipe_src

// ==== test/arp_round_core_test.sv ====
// Purpose: self-checking bench for the round core
// Assumes: 20 MHz clock, result one cycle after request
// Notes:   expected values rebuilt here from field arithmetic
`timescale 1ns/1ps
module arp_round_core_test;
	logic         clk_i, rst_n_i, valid_i, valid_o, illegal_o;
	logic [3:0]   op_i, rounds_o;
	logic [127:0] state_i, key_i, result_o, s, k;
	logic [7:0]   imm_i, y, b, sbt[256], isbt[256];
	logic [1:0]   key_len_i;
	logic [132:0] e, exp_q[$];
	int           fails, checks, seed;
	arp_pipe_src src_u (.clk_i(clk_i), .valid_o(valid_i), .op_o(op_i), .st_o(state_i),
		.key_o(key_i), .imm_o(imm_i), .len_o(key_len_i));
	arp_round_core dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .valid_i(valid_i), .op_i(op_i),
		.state_i(state_i), .key_i(key_i), .imm_i(imm_i), .key_len_i(key_len_i),
		.valid_o(valid_o), .result_o(result_o), .rounds_o(rounds_o), .illegal_o(illegal_o));
	// --------------------
	// reference arithmetic
	// --------------------
	function automatic logic [7:0] gmul(input logic [7:0] a, c);
		logic [7:0] p;
		p = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (c[i]) p ^= a;
			a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
		end
		return p;
	endfunction
	// row r moves left by r*d columns; d of 3 undoes d of 1
	function automatic logic [127:0] rr(input logic [127:0] x, input int d);
		for (int i = 0; i < 16; i++)
			rr[i*8+:8] = x[((i/4+(i%4)*d)%4*4+i%4)*8+:8];
	endfunction
	function automatic logic [127:0] mix(input logic [127:0] x, input logic [31:0] cf);
		mix = 128'h0;
		for (int i = 0; i < 16; i++)
			for (int j = 0; j < 4; j++)
				mix[i*8+:8] ^= gmul(cf[((j-i)&3)*8+:8], x[(i/4*4+j)*8+:8]);
	endfunction
	function automatic logic [127:0] sub(input logic [127:0] x, input bit inv);
		for (int i = 0; i < 16; i++)
			sub[i*8+:8] = inv ? isbt[x[i*8+:8]] : sbt[x[i*8+:8]];
	endfunction
	function automatic logic [127:0] expv(input logic [3:0] op, input logic [127:0] x, kk, input logic [7:0] im);
		logic [127:0] t, p;
		logic [63:0]  ma, mb;
		t = sub(x, 1'b0);
		p = 128'h0;
		ma = im[0] ? x[127:64] : x[63:0];
		mb = im[4] ? kk[127:64] : kk[63:0];
		for (int i = 0; i < 64; i++)
			if (mb[i]) p ^= {64'h0, ma} << i;
		case (op)
		4'h0: return mix(sub(rr(x, 1), 1'b0), 32'h01010302) ^ kk;
		4'h1: return sub(rr(x, 1), 1'b0) ^ kk;
		4'h2: return mix(sub(rr(x, 3), 1'b1), 32'h090d0b0e) ^ kk;
		4'h3: return sub(rr(x, 3), 1'b1) ^ kk;
		4'h4: return mix(x, 32'h090d0b0e);
		4'h5: return {{t[103:96], t[127:104]} ^ {24'h0, im}, t[127:96], {t[39:32], t[63:40]} ^ {24'h0, im}, t[63:32]};
		4'h6: return p;
		4'h7: return rr(x, 1);
		4'h8: return rr(x, 3);
		4'h9: return t;
		4'ha: return sub(x, 1'b1);
		4'hb: return mix(x, 32'h01010302);
		4'hc: return {96'h0, t[31:0]};
		4'hd: return {96'h0, x[7:0], x[31:8]};
		default: return 128'h0;
		endcase
	endfunction
	// ------------------------
	// drive, compare, finish
	// ------------------------
	task automatic go(input logic [3:0] op, input logic [1:0] kl);
		exp_q.push_back({op[3:1] == 3'h7, kl == 2'h3 ? 4'h0 : 4'ha + {1'b0, kl, 1'b0}, expv(op, s, k, y)});
		src_u.send(op, s, k, y, kl);
	endtask
	task automatic lit(input logic [3:0] op, input logic [127:0] x, ex);
		exp_q.push_back({5'h0a, ex});
		src_u.send(op, x, k, 8'h00, 2'h0);
	endtask
	task automatic cmp_res(input string nm, input logic [127:0] ex, g);
		checks++;
		if (g !== ex) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, g);
		end
	endtask
	task automatic cmp_fld(input string nm, input logic [3:0] ex, g);
		checks++;
		if (g !== ex) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, g);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// clock at 50 ns
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// run needs about 110 cycles, cut at 3000
	initial begin
		#(3000 * 50);
		fails++;
		wrap_up();
	end
	// oldest note against each result; empty queue gives x, which never matches
	always @(negedge clk_i) begin
		if (valid_o === 1'b1) begin
			e = exp_q.size() ? exp_q.pop_front() : 'x;
			cmp_res("result", e[127:0], result_o);
			cmp_fld("rounds", e[131:128], rounds_o);
			cmp_fld("illegal", {3'h0, e[132]}, {3'h0, illegal_o});
		end
	end
	// tables from field inverse and affine map, then every op, an idle cycle after every fifth request
	initial begin
		rst_n_i = 1'b0;
		seed = 11061;
		for (int x = 0; x < 256; x++) begin
			y = 8'h00;
			for (int z = 1; z < 256; z++)
				if (gmul(x[7:0], z[7:0]) == 8'h01) y = z[7:0];
			b = y ^ {y[6:0], y[7]} ^ {y[5:0], y[7:6]} ^ {y[4:0], y[7:5]} ^ {y[3:0], y[7:4]} ^ 8'h63;
			sbt[x] = b;
			isbt[b] = x[7:0];
		end
		repeat (20) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		for (int n = 0; n < 64; n++) begin
			s = {$random(seed), $random(seed), $random(seed), $random(seed)};
			k = {$random(seed), $random(seed), $random(seed), $random(seed)};
			y = 8'($random(seed));
			go(n[3:0], 2'(n / 16));
			if (n % 5 == 4) src_u.idle();
		end
		lit(4'h9, {8'hff, 120'h0}, {8'h16, {15{8'h63}}});
		lit(4'ha, 128'h0, {16{8'h52}});
		lit(4'h7, 128'he598271ef11141b8ae52b4e0305dbfd4, 128'hf152bf1eae5d27b8309841e0e511b4d4);
		src_u.idle();
		repeat (2) @(posedge clk_i);
		#1 rst_n_i = 1'b0;
		@(negedge clk_i);
		cmp_res("reset result", 128'h0, result_o);
		cmp_fld("reset valid", 4'h0, {3'h0, valid_o});
		@(posedge clk_i);
		#1 rst_n_i = 1'b1;
		go(4'hd, 2'h3);
		src_u.idle();
		repeat (3) @(posedge clk_i);
		cmp_fld("notes left", 4'h0, 4'(exp_q.size()));
		wrap_up();
	end
endmodule // arp_round_core_test
